//--- common/cise_pkg.sv
/*
 Constants for the partial instruction executor: opcodes, flag bit positions,
 cycle counts, trap vector and reset values. Assumes a 16-bit address space
 and an 8-bit data bus with one-cycle synchronous memory reads.
*/
package cise_pkg;
   // ==========================================================
   // Opcodes
   localparam logic [7:0] OP_SUB_LIT   = 8'ha0;
   localparam logic [7:0] OP_SUB_DIR   = 8'hb0;
   localparam logic [7:0] OP_SUB_FAR   = 8'hc0;
   localparam logic [7:0] OP_SUB_WIX   = 8'hd0;
   localparam logic [7:0] OP_SUB_BIX   = 8'he0;
   localparam logic [7:0] OP_SUB_IX    = 8'hf0;
   localparam logic [7:0] OP_SOFT_TRAP = 8'h83;
   localparam logic [7:0] OP_A_TO_X    = 8'h97;
   localparam logic [7:0] OP_X_TO_A    = 8'h9f;
   localparam logic [7:0] OP_CHK_DIR   = 8'h3d;
   localparam logic [7:0] OP_CHK_ACC   = 8'h4d;
   localparam logic [7:0] OP_CHK_IDX   = 8'h5d;
   localparam logic [7:0] OP_CHK_BIX   = 8'h6d;
   localparam logic [7:0] OP_CHK_IX    = 8'h7d;
   localparam logic [7:0] OP_WAIT      = 8'h8f;
   // Bit-test-and-branch opcodes occupy 0x00..0x0f; bit 0 selects clear/set.
   localparam logic [3:0] BTB_HI_NIB   = 4'h0;

   // ==========================================================
   // Flag register layout: 111HINZC
   localparam int FLG_C = 0;
   localparam int FLG_Z = 1;
   localparam int FLG_N = 2;
   localparam int FLG_I = 3;
   localparam int FLG_H = 4;
   localparam logic [7:0] FLG_RESET = 8'hf8;

   // ==========================================================
   // Reset values and sizes
   localparam logic [15:0] PC_RESET    = 16'h0000;
   localparam logic [7:0]  SP_RESET    = 8'hff;
   localparam logic [7:0]  STACK_PAGE  = 8'h00;
   localparam logic [15:0] TRAP_VEC_HI = 16'hfffc;
   localparam logic [15:0] TRAP_VEC_LO = 16'hfffd;
   localparam logic [15:0] PC_ONE      = 16'h0001;
   localparam logic [7:0]  BYTE_ZERO   = 8'h00;
   localparam int          SIGN_BIT    = 7;
   localparam int          BIT_SEL_LSB = 1;
   localparam int          BIT_SEL_W   = 3;
   localparam int          CNT_W       = 4;
   // Least cycle count of the register copies and of the wait instruction.
   localparam logic [3:0]  CYC_COPY    = 4'h2;
   localparam logic [3:0]  CYC_WAIT    = 4'h2;

   typedef enum logic [3:0] {
      CISE_FETCH  = 4'b0000,
      CISE_OPR1   = 4'b0001,
      CISE_OPR2   = 4'b0011,
      CISE_READ   = 4'b0010,
      CISE_EXEC   = 4'b0110,
      CISE_REL    = 4'b0111,
      CISE_PUSH   = 4'b0101,
      CISE_VECH   = 4'b0100,
      CISE_VECL   = 4'b1100,
      CISE_HOLD   = 4'b1101,
      CISE_SLEEP  = 4'b1111
   } cise_state_t;
endpackage : cise_pkg

//--- hw/cise_core.sv
/*
 Executes a subset of an 8-bit core's instructions: subtract, software trap,
 register copies, flag check and wait, plus operand fetch for the far,
 direct, indexed and relative modes. Assumes memory returns mem_rdata in
 the cycle that the registered mem_rd stands, and that writes complete in the
 cycle mem_wr is high. Unhandled opcodes execute as three-cycle no-ops.
*/
`timescale 1ns/1ps
// How it works
// - Subtract replaces A with A minus the operand and sets N, Z and C for opcodes a0..f0.
// - Soft trap steps PC, pushes PC low, PC high, X, A, flags with SP dropping, sets I, loads vector high first.
// - Opcode 97 copies A into X in two cycles and touches no flag.
// - The flag check sets N and Z from its operand and leaves H, I and C alone.
// - Opcode 9f copies X into A in two cycles and touches no flag.
// - Wait clears I in two cycles and then halts until an interrupt arrives.
// - Far mode fetches the address high byte first, then the low byte.
// - Word-offset indexed mode fetches offset high then low and adds X.
// - Byte-offset indexed mode fetches one offset byte and adds X.
// - Bit-test-and-branch carries a direct address then a relative offset added when taken.
module cise_core #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset,
   // Memory bus
   output logic [ADDR_W-1:0]      mem_addr,
   output logic                   mem_rd,
   output logic                   mem_wr,
   output logic [7:0]             mem_wdata,
   input  wire logic [7:0]        mem_rdata,
   // Interrupt wake request, from outside the clock domain
   input  wire logic              irq_req,
   // Status
   output logic                   sleeping,
   output logic [7:0]             acc_out,
   output logic [7:0]             index_out,
   output logic [7:0]             flag_register_out,
   output logic [ADDR_W-1:0]      pc_out
);
   // ==========================================================
   // Wake input synchroniser
   logic [2:0] irq_sync_q;
   logic [2:0] irq_sync_d;
   logic       irq_seen;

   always_comb begin
      irq_sync_d = {irq_sync_q[1:0], irq_req};
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         irq_sync_q <= 3'h0;
      end else begin
         irq_sync_q <= irq_sync_d;
      end
   end

   assign irq_seen = irq_sync_q[1] & irq_sync_q[2];

   // ==========================================================
   // Core state
   cise_pkg::cise_state_t state_q, state_d;
   logic [ADDR_W-1:0] pc_q, pc_d;
   logic [ADDR_W-1:0] ea_q, ea_d;
   logic [7:0]        acc_q, acc_d;
   logic [7:0]        idx_q, idx_d;
   logic [7:0]        sp_q, sp_d;
   logic [7:0]        flg_q, flg_d;
   logic [7:0]        op_q, op_d;
   logic [7:0]        opr_q, opr_d;
   logic [cise_pkg::CNT_W-1:0] cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_d;
   logic              rd_d, wr_d;
   logic [7:0]        wdata_d;
   logic [ADDR_W-1:0] addr_q;
   logic              rd_q, wr_q;
   logic [7:0]        wdata_q;

   // Operand bytes needed after the opcode: 0, 1 or 2.
   function automatic logic [1:0] opr_bytes(input logic [7:0] op);
      logic [1:0] n;
      n = 2'd0;
      unique case (op)
         cise_pkg::OP_SUB_LIT, cise_pkg::OP_SUB_DIR, cise_pkg::OP_SUB_BIX,
         cise_pkg::OP_CHK_DIR, cise_pkg::OP_CHK_BIX: n = 2'd1;
         cise_pkg::OP_SUB_FAR, cise_pkg::OP_SUB_WIX: n = 2'd2;
         default: n = (op[7:4] == cise_pkg::BTB_HI_NIB) ? 2'd2 : 2'd0;
      endcase
      return n;
   endfunction

   function automatic logic is_sub(input logic [7:0] op);
      return op == cise_pkg::OP_SUB_LIT || op == cise_pkg::OP_SUB_DIR ||
             op == cise_pkg::OP_SUB_FAR || op == cise_pkg::OP_SUB_WIX ||
             op == cise_pkg::OP_SUB_BIX || op == cise_pkg::OP_SUB_IX;
   endfunction

   logic [8:0] diff;
   logic [7:0] chk_val;
   logic       bit_hit;

   always_comb begin
      state_d = state_q;
      pc_d    = pc_q;
      ea_d    = ea_q;
      acc_d   = acc_q;
      idx_d   = idx_q;
      sp_d    = sp_q;
      flg_d   = flg_q;
      op_d    = op_q;
      opr_d   = opr_q;
      cnt_d   = cnt_q;
      addr_d  = pc_q;
      rd_d    = 1'b0;
      wr_d    = 1'b0;
      wdata_d = cise_pkg::BYTE_ZERO;
      // The literal was captured one cycle before execute; the bus is idle by then.
      diff    = {1'b0, acc_q} -
                {1'b0, (op_q == cise_pkg::OP_SUB_LIT) ? opr_q : mem_rdata};
      chk_val = mem_rdata;
      bit_hit = mem_rdata[op_q[cise_pkg::BIT_SEL_LSB +: cise_pkg::BIT_SEL_W]] ^ op_q[0];
      unique case (state_q)
         cise_pkg::CISE_FETCH: begin
            addr_d  = pc_q;
            rd_d    = 1'b1;
            state_d = cise_pkg::CISE_OPR1;
            cnt_d   = '0;
            pc_d    = pc_q + cise_pkg::PC_ONE;
         end
         cise_pkg::CISE_OPR1: begin
            // Opcode arrives now; start the first operand fetch if any.
            op_d  = mem_rdata;
            cnt_d = cnt_q + 1'b1;
            if (opr_bytes(mem_rdata) != 2'd0) begin
               addr_d  = pc_q;
               rd_d    = 1'b1;
               pc_d    = pc_q + cise_pkg::PC_ONE;
               state_d = cise_pkg::CISE_OPR2;
            end else if (mem_rdata == cise_pkg::OP_SUB_IX ||
                         mem_rdata == cise_pkg::OP_CHK_IX) begin
               addr_d  = {{(ADDR_W-8){1'b0}}, idx_q};
               rd_d    = 1'b1;
               state_d = cise_pkg::CISE_EXEC;
            end else if (mem_rdata == cise_pkg::OP_A_TO_X) begin
               // Copies and wait finish at decode so they take two cycles.
               idx_d   = acc_q;
               state_d = cise_pkg::CISE_FETCH;
            end else if (mem_rdata == cise_pkg::OP_X_TO_A) begin
               acc_d   = idx_q;
               state_d = cise_pkg::CISE_FETCH;
            end else if (mem_rdata == cise_pkg::OP_WAIT) begin
               flg_d[cise_pkg::FLG_I] = 1'b0;
               state_d = cise_pkg::CISE_SLEEP;
            end else begin
               state_d = cise_pkg::CISE_EXEC;
            end
         end
         cise_pkg::CISE_OPR2: begin
            cnt_d = cnt_q + 1'b1;
            opr_d = mem_rdata;
            ea_d  = {{(ADDR_W-8){1'b0}}, mem_rdata};
            if (opr_bytes(op_q) == 2'd2 && op_q[7:4] != cise_pkg::BTB_HI_NIB) begin
               // Second byte is the low half; high half came first.
               addr_d  = pc_q;
               rd_d    = 1'b1;
               pc_d    = pc_q + cise_pkg::PC_ONE;
               state_d = cise_pkg::CISE_READ;
            end else if (op_q == cise_pkg::OP_SUB_LIT) begin
               state_d = cise_pkg::CISE_EXEC;
            end else begin
               if (op_q == cise_pkg::OP_SUB_BIX || op_q == cise_pkg::OP_CHK_BIX) begin
                  ea_d = {{(ADDR_W-8){1'b0}}, mem_rdata} +
                         {{(ADDR_W-8){1'b0}}, idx_q};
               end
               addr_d  = ea_d;
               rd_d    = 1'b1;
               state_d = (op_q[7:4] == cise_pkg::BTB_HI_NIB) ?
                         cise_pkg::CISE_REL : cise_pkg::CISE_EXEC;
               if (op_q[7:4] == cise_pkg::BTB_HI_NIB) begin
                  pc_d = pc_q;
               end
            end
         end
         cise_pkg::CISE_READ: begin
            cnt_d = cnt_q + 1'b1;
            ea_d  = {opr_q, mem_rdata};
            if (op_q == cise_pkg::OP_SUB_WIX) begin
               ea_d = {opr_q, mem_rdata} + {{(ADDR_W-8){1'b0}}, idx_q};
            end
            addr_d  = ea_d;
            rd_d    = 1'b1;
            state_d = cise_pkg::CISE_EXEC;
         end
         cise_pkg::CISE_REL: begin
            // Direct byte is in; fetch the branch offset byte.
            cnt_d   = cnt_q + 1'b1;
            opr_d   = {7'h00, bit_hit};
            flg_d[cise_pkg::FLG_C] = mem_rdata[op_q[cise_pkg::BIT_SEL_LSB +: cise_pkg::BIT_SEL_W]];
            addr_d  = pc_q;
            rd_d    = 1'b1;
            pc_d    = pc_q + cise_pkg::PC_ONE;
            op_d    = op_q;
            state_d = cise_pkg::CISE_HOLD;
         end
         cise_pkg::CISE_HOLD: begin
            // Offset byte is in; branch taken when the tested bit matches.
            if (opr_q[0]) begin
               pc_d = pc_q + {{(ADDR_W-8){mem_rdata[cise_pkg::SIGN_BIT]}}, mem_rdata};
            end
            state_d = cise_pkg::CISE_FETCH;
         end
         cise_pkg::CISE_EXEC: begin
            cnt_d   = cnt_q + 1'b1;
            state_d = cise_pkg::CISE_FETCH;
            if (is_sub(op_q)) begin
               acc_d = diff[7:0];
               flg_d[cise_pkg::FLG_N] = diff[cise_pkg::SIGN_BIT];
               flg_d[cise_pkg::FLG_Z] = (diff[7:0] == cise_pkg::BYTE_ZERO);
               flg_d[cise_pkg::FLG_C] = diff[8];
            end else begin
               unique case (op_q)
                  cise_pkg::OP_CHK_DIR, cise_pkg::OP_CHK_ACC, cise_pkg::OP_CHK_IDX,
                  cise_pkg::OP_CHK_BIX, cise_pkg::OP_CHK_IX: begin
                     // Only N and Z move; the operand is never written back.
                     chk_val = (op_q == cise_pkg::OP_CHK_ACC) ? acc_q :
                               (op_q == cise_pkg::OP_CHK_IDX) ? idx_q : mem_rdata;
                     flg_d[cise_pkg::FLG_N] = chk_val[cise_pkg::SIGN_BIT];
                     flg_d[cise_pkg::FLG_Z] = (chk_val == cise_pkg::BYTE_ZERO);
                  end
                  cise_pkg::OP_SOFT_TRAP: begin
                     // PC already points past the opcode.
                     cnt_d   = '0;
                     state_d = cise_pkg::CISE_PUSH;
                  end
                  default: ;
               endcase
            end
         end
         cise_pkg::CISE_PUSH: begin
            // Push order: PC low, PC high, X, A, flags.
            addr_d = {cise_pkg::STACK_PAGE, sp_q};
            wr_d   = 1'b1;
            unique case (cnt_q)
               4'h0:    wdata_d = pc_q[7:0];
               4'h1:    wdata_d = pc_q[15:8];
               4'h2:    wdata_d = idx_q;
               4'h3:    wdata_d = acc_q;
               default: wdata_d = flg_q;
            endcase
            sp_d  = sp_q - 8'h01;
            cnt_d = cnt_q + 1'b1;
            if (cnt_q == 4'h4) begin
               flg_d[cise_pkg::FLG_I] = 1'b1;
               state_d = cise_pkg::CISE_VECH;
            end
         end
         cise_pkg::CISE_VECH: begin
            addr_d  = cise_pkg::TRAP_VEC_HI;
            rd_d    = 1'b1;
            state_d = cise_pkg::CISE_VECL;
         end
         cise_pkg::CISE_VECL: begin
            pc_d[15:8] = mem_rdata;
            addr_d  = cise_pkg::TRAP_VEC_LO;
            rd_d    = 1'b1;
            state_d = cise_pkg::CISE_SLEEP;
            op_d    = cise_pkg::OP_SOFT_TRAP;
         end
         cise_pkg::CISE_SLEEP: begin
            if (op_q == cise_pkg::OP_SOFT_TRAP) begin
               pc_d[7:0] = mem_rdata;
               op_d      = cise_pkg::BYTE_ZERO;
               state_d   = cise_pkg::CISE_FETCH;
            end else if (irq_seen) begin
               // State held until the interrupt; service is outside this block.
               state_d = cise_pkg::CISE_FETCH;
            end
         end
         default: state_d = cise_pkg::CISE_FETCH;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_q <= cise_pkg::CISE_FETCH;
         pc_q    <= cise_pkg::PC_RESET;
         ea_q    <= '0;
         acc_q   <= cise_pkg::BYTE_ZERO;
         idx_q   <= cise_pkg::BYTE_ZERO;
         sp_q    <= cise_pkg::SP_RESET;
         flg_q   <= cise_pkg::FLG_RESET;
         op_q    <= cise_pkg::BYTE_ZERO;
         opr_q   <= cise_pkg::BYTE_ZERO;
         cnt_q   <= '0;
         addr_q  <= '0;
         rd_q    <= 1'b0;
         wr_q    <= 1'b0;
         wdata_q <= cise_pkg::BYTE_ZERO;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         ea_q    <= ea_d;
         acc_q   <= acc_d;
         idx_q   <= idx_d;
         sp_q    <= sp_d;
         flg_q   <= flg_d;
         op_q    <= op_d;
         opr_q   <= opr_d;
         cnt_q   <= cnt_d;
         addr_q  <= addr_d;
         rd_q    <= rd_d;
         wr_q    <= wr_d;
         wdata_q <= wdata_d;
      end
   end

   assign mem_addr          = addr_q;
   assign mem_rd            = rd_q;
   assign mem_wr            = wr_q;
   assign mem_wdata         = wdata_q;
   assign sleeping          = (state_q == cise_pkg::CISE_SLEEP) &&
                              (op_q != cise_pkg::OP_SOFT_TRAP);
   assign acc_out           = acc_q;
   assign index_out         = idx_q;
   assign flag_register_out = flg_q;
   assign pc_out            = pc_q;
endmodule : cise_core

//--- dv/cise_core_checker.sv
/*
 Concurrent checks on the ports of the partial instruction executor.
 Assumes one clock, a synchronous active-high reset and a stack in page 00.
*/
`timescale 1ns/1ps
module cise_core_checker #(
   parameter int ADDR_W = 16
) (
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset,
   // Memory bus
   input wire logic [ADDR_W-1:0] mem_addr,
   input wire logic              mem_rd,
   input wire logic              mem_wr,
   input wire logic [7:0]        mem_wdata,
   input wire logic [7:0]        mem_rdata,
   // Wake request and status
   input wire logic              irq_req,
   input wire logic              sleeping,
   input wire logic [7:0]        acc_out,
   input wire logic [7:0]        index_out,
   input wire logic [7:0]        flag_register_out,
   input wire logic [ADDR_W-1:0] pc_out
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   // ==========================================================
   // Trap stacking and vector fetch
   push_count_a: assert property (mem_wr && !$past(mem_wr) |-> mem_wr [*5] ##1 !mem_wr)
      else $error("trap push burst is not five writes");
   push_down_a: assert property (mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 1)
      else $error("stack address did not drop by one");
   push_regs_a: assert property (mem_wr && !$past(mem_wr) |-> ##2 mem_wdata == index_out
      ##1 mem_wdata == acc_out ##1 mem_wdata == $past(flag_register_out))
      else $error("pushed register bytes out of order");
   vec_fetch_a: assert property ($fell(mem_wr) |-> mem_rd && mem_addr == 16'hfffc ##1
      mem_rd && mem_addr == 16'hfffd ##[1:3] flag_register_out[3])
      else $error("vector not read high then low with mask set");
   // ==========================================================
   // Wait and flags
   sleep_mask_a: assert property ($rose(sleeping) |-> !flag_register_out[3])
      else $error("halted with interrupt mask still set");
   sleep_quiet_a: assert property (sleeping |-> !mem_rd && !mem_wr && $stable(pc_out))
      else $error("bus activity while halted");
   wake_bound_a: assert property (sleeping && irq_req |-> ##[1:6] !sleeping)
      else $error("no wake after interrupt request");
   half_kept_a: assert property (!$changed(flag_register_out[4]))
      else $error("half carry changed");
endmodule : cise_core_checker

bind cise_core cise_core_checker #(.ADDR_W(ADDR_W)) chk (
   .clk_sys(clk_sys), .reset(reset), .mem_addr(mem_addr), .mem_rd(mem_rd),
   .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
   .sleeping(sleeping), .acc_out(acc_out), .index_out(index_out),
   .flag_register_out(flag_register_out), .pc_out(pc_out));

//--- dv/cise_mem_model.sv
/*
 Behavioural program and data memory on the core's internal bus.
 The core registers its own address, so read data appears in the cycle that
 mem_rd stands; writes land at the edge.
*/
`timescale 1ns/1ps
module cise_mem_model (
   // Clock
   input wire logic        clk_sys,
   // Bus from the core
   input wire logic [15:0] mem_addr,
   input wire logic        mem_rd,
   input wire logic        mem_wr,
   input wire logic [7:0]  mem_wdata,
   output logic [7:0]      mem_rdata
);
   logic [7:0] ram [0:65535];
   logic [7:0] idle_q = 8'h00;

   // Outside a read the data is inverted each cycle so a stale sample cannot pass.
   always @(posedge clk_sys) begin
      idle_q <= ~mem_rdata;
      if (mem_wr) ram[mem_addr] <= mem_wdata;
   end

   assign mem_rdata = mem_rd ? ram[mem_addr] : idle_q;
endmodule : cise_mem_model

//--- dv/cise_core_bench.sv
/*
 Self-checking bench for the partial instruction executor: runs one program
 through subtract, copies, flag check, bit branches, wait and trap.
 Assumes the memory model answers a read in the cycle that mem_rd stands.
*/
`timescale 1ns/1ps
module cise_core_bench;
   logic        clk_sys;
   logic        reset;
   logic [15:0] mem_addr;
   logic        mem_rd;
   logic        mem_wr;
   logic [7:0]  mem_wdata;
   logic [7:0]  mem_rdata;
   logic        irq_req;
   logic        sleeping;
   logic [7:0]  acc_out;
   logic [7:0]  index_out;
   logic [7:0]  flag_register_out;
   logic [15:0] pc_out;
   int          err_total = 0;
   int          n_tests = 0;
   int          cyc = 0;
   int          last_fetch;
   logic [7:0]  prog [33] = '{8'ha0, 8'h05, 8'h97, 8'hc0, 8'h12, 8'h34, 8'h9f, 8'hd0, 8'h10,
      8'h00, 8'he0, 8'h02, 8'hf0, 8'hb0, 8'h40, 8'h3d, 8'h41, 8'h4d, 8'h6d, 8'h03, 8'h7d,
      8'h00, 8'h41, 8'h05, 8'h01, 8'h41, 8'h03, 8'h9f, 8'h9f, 8'h9f, 8'h8f, 8'h5d, 8'h83};

   cise_core #(.ADDR_W(16)) dut (
      .clk_sys(clk_sys), .reset(reset), .mem_addr(mem_addr), .mem_rd(mem_rd),
      .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
      .sleeping(sleeping), .acc_out(acc_out), .index_out(index_out),
      .flag_register_out(flag_register_out), .pc_out(pc_out));
   cise_mem_model mem (
      .clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr),
      .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

   initial begin
      clk_sys = 1'b0;
      forever #2.5 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys) cyc <= cyc + 1;

   // ==========================================================
   // Shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic final_report;
      if (err_total == 0 && n_tests > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : final_report

   // Waits for the opcode fetch at pc, then compares the registers.
   task automatic step(input logic [15:0] pc, input logic [7:0] a, x, f);
      int n;
      n = 0;
      while (!(mem_rd === 1'b1 && mem_addr === pc) && n < 200) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      last_fetch = cyc;
      check(mem_addr, pc);
      check(acc_out, a);
      check(index_out, x);
      check(flag_register_out, f);
   endtask : step

   // ==========================================================
   // Scenarios
   task automatic run_sub_copy;
      int t0;
      step(16'h0002, 8'hfb, 8'h00, 8'hfd);
      t0 = last_fetch;
      step(16'h0003, 8'hfb, 8'hfb, 8'hfd);
      check(16'(last_fetch - t0), 16'h0002);
      step(16'h0006, 8'h00, 8'hfb, 8'hfa);
      t0 = last_fetch;
      step(16'h0007, 8'hfb, 8'hfb, 8'hfa);
      check(16'(last_fetch - t0), 16'h0002);
      step(16'h000a, 8'hfa, 8'hfb, 8'hfc);
      step(16'h000c, 8'heb, 8'hfb, 8'hfc);
      step(16'h000d, 8'h00, 8'hfb, 8'hfa);
      step(16'h000f, 8'hff, 8'hfb, 8'hfd);
   endtask : run_sub_copy

   task automatic run_check_branch;
      step(16'h0011, 8'hff, 8'hfb, 8'hfb);
      step(16'h0012, 8'hff, 8'hfb, 8'hfd);
      step(16'h0014, 8'hff, 8'hfb, 8'hfd);
      step(16'h0015, 8'hff, 8'hfb, 8'hfd);
      check(mem.ram[16'h0041], 16'h0000);
      check(mem.ram[16'h00fe], 16'h0080);
      step(16'h0018, 8'hff, 8'hfb, 8'hfc);
      step(16'h001e, 8'hff, 8'hfb, 8'hfc);
   endtask : run_check_branch

   task automatic run_wait_trap;
      logic [7:0] stk [5] = '{8'h21, 8'h00, 8'hfb, 8'hff, 8'hf4};
      int         n;
      n = 0;
      while (sleeping !== 1'b1 && n < 20) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      repeat (10) @(posedge clk_sys);
      #1;
      check(sleeping, 16'h0001);
      check(flag_register_out, 16'h00f4);
      check(pc_out, 16'h001f);
      @(posedge clk_sys);
      irq_req <= 1'b1;
      step(16'h001f, 8'hff, 8'hfb, 8'hf4);
      step(16'h0020, 8'hff, 8'hfb, 8'hf4);
      step(16'h0300, 8'hff, 8'hfb, 8'hfc);
      @(posedge clk_sys);
      irq_req <= 1'b0;
      for (int i = 0; i < 5; i++) begin
         check(mem.ram[16'h00ff - 16'(i)], stk[i]);
      end
   endtask : run_wait_trap

   // ==========================================================
   // Main sequence and watchdog
   initial begin
      reset = 1'b1;
      irq_req = 1'b0;
      #1;
      for (int i = 0; i < 33; i++) mem.ram[i] = prog[i];
      mem.ram[16'h1234] = 8'hfb;
      mem.ram[16'h10fb] = 8'h01;
      mem.ram[16'h00fd] = 8'h0f;
      mem.ram[16'h00fb] = 8'heb;
      mem.ram[16'h0040] = 8'h01;
      mem.ram[16'h0041] = 8'h00;
      mem.ram[16'h00fe] = 8'h80;
      mem.ram[16'hfffc] = 8'h03;
      mem.ram[16'hfffd] = 8'h00;
      mem.ram[16'h0300] = 8'h9d;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      run_sub_copy();
      run_check_branch();
      run_wait_trap();
      final_report();
   end

   // The program needs some 90 cycles; over twenty times that means a hang.
   initial begin
      #10000;
      err_total++;
      final_report();
   end
endmodule : cise_core_bench
